// *** hw/rdcr_pkg.sv ***
// Constants shared by the receive data and clock recovery block.
// Assumes one crystal clock drives all logic of the block.
package rdcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_DIV   = 8'h04;
    localparam logic [7:0] OFS_STAT  = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;

    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_TWO_BIT   = 2;
    localparam int CTRL_TCNT_LSB  = 3;
    localparam int DIV_D1_LSB     = 0;
    localparam int DIV_D2_LSB     = 2;
    localparam int DIV_D3_BIT     = 5;
    localparam int STAT_TRAIN_BIT = 0;
    localparam int STAT_SYNC_BIT  = 1;

    localparam logic [1:0] MODE_RST  = 2'h0;
    localparam logic       TWO_RST   = 1'h0;
    localparam logic [4:0] TCNT_RST  = 5'h00;
    localparam logic [1:0] D1_RST    = 2'h0;
    localparam logic [2:0] D2_RST    = 3'h0;
    localparam logic       D3_RST    = 1'h0;
    localparam logic [1:0] STAT_RST  = 2'h0;
    localparam logic [1:0] MASK_RST  = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    localparam int         CLK_HZ      = 40000000;
    localparam logic [4:0] D3_LOW      = 5'h0F;
    localparam logic [4:0] D3_HIGH     = 5'h10;
    localparam int         DG_TAPS     = 7;
    localparam logic [2:0] DG_HIGH_MIN = 3'h5;
    localparam logic [2:0] DG_LOW_MAX  = 3'h2;
    localparam logic [6:0] TRAIN_BASE  = 7'h02;
    localparam logic [6:0] TRAIN_SAT   = 7'h7F;

    typedef enum logic [1:0] {
        RDCR_RAW,
        RDCR_DEGLITCH,
        RDCR_RECOVER,
        RDCR_TRAIN
    } rdcr_mode_e;

    // First rate divisor: code 0..3 selects 1, 5, 6 or 8.
    function automatic logic [3:0] rdcr_d1_value(input logic [1:0] code);
        unique case (code)
            2'h0: rdcr_d1_value = 4'h1;
            2'h1: rdcr_d1_value = 4'h5;
            2'h2: rdcr_d1_value = 4'h6;
            2'h3: rdcr_d1_value = 4'h8;
        endcase
    endfunction

endpackage

// *** hw/rdcr_div.sv ***
// Oversampling divider: one sample enable every first times second divisor.
// Assumes divisor codes come from registers on the same clock.
`timescale 1ns/1ps
module rdcr_div
    import rdcr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] rate_divisor_first,
    input  wire logic [2:0] rate_divisor_second,
    output logic            sample_en,
    output logic            os_clk
);

    typedef struct packed {
        logic [10:0] cnt;
    } rdcr_div_s;

    rdcr_div_s   st_r;
    rdcr_div_s   st_nxt;
    logic [10:0] period;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        period    = 11'({7'h00, rdcr_d1_value(rate_divisor_first)} << rate_divisor_second); // R16
        st_nxt    = st_r;
        sample_en = (st_r.cnt >= period - 11'h001); // R3
        os_clk    = (st_r.cnt < (period >> 1));
        if (sample_en) begin
            st_nxt.cnt = 11'h000;
        end else begin
            st_nxt.cnt = st_r.cnt + 11'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// *** hw/rdcr_dglt.sv ***
// Majority deglitch filter over the latest samples of the slicer bit.
// Assumes the input is already synchronised to the clock.
`timescale 1ns/1ps
module rdcr_dglt
    import rdcr_pkg::*;
#(
    parameter int TAPS = DG_TAPS
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sample_en,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic [TAPS-1:0] sh;
        logic            q;
    } rdcr_dglt_s;

    rdcr_dglt_s      st_r;
    rdcr_dglt_s      st_nxt;
    logic [TAPS-1:0] shifted;
    logic [2:0]      ones;

    function automatic logic [2:0] count_ones(input logic [TAPS-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < TAPS; i++) begin
            n = n + 3'(v[i]);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt  = st_r;
        shifted = {st_r.sh[TAPS-2:0], din};
        ones    = count_ones(shifted);
        if (sample_en) begin
            st_nxt.sh = shifted; // R3
            if (ones >= DG_HIGH_MIN) begin
                st_nxt.q = 1'b1; // R4
            end else if (ones <= DG_LOW_MAX) begin
                st_nxt.q = 1'b0; // R4
            end
        end
        dout = st_r.q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// *** hw/rdcr_top.sv ***
// Receive data recovery: raw, deglitched, clock recovered and self train
// modes, with a small register port, sticky event status and an interrupt.
// Assumes the slicer bit arrives asynchronously on a pin and the register
// master runs on the same crystal clock.
`timescale 1ns/1ps

// Behaviour
// R1: A two-bit mode field picks raw, deglitch, clock recovery or self train.
// R2: Raw mode passes the slicer bit through and holds bit clock and flag low.
// R3: Deglitch sampling runs at the crystal rate over first times second divisor.
// R4: The filter goes high on five of seven high samples, low on two or fewer, else holds.
// R5: Deglitch mode outputs filtered data with the oversampling clock, flag low.
// R6: Clock recovery aligns a bit clock to deglitched data edges, flag low.
// R7: Recovered data changes on the falling edge of the bit clock.
// R8: The controller captures data on each rising edge of the bit clock.
// R9: The bit clock stays low after reset until the first data edge is seen.
// R10: The sender keeps runs of equal bits below 250000 over the rate error in ppm.
// R11: The pattern bit selects alternating single bits or alternating bit pairs.
// R12: After enough training bits the flag pulses one bit period at the first other bit.
// R13: The minimum training length is four times the count field plus pattern bit plus two.
// R14: Recovery and training logic reinitialise themselves without any command.
// R15: The rising edge of the bit clock sits at the centre of each data bit.
// R16: Bit rate is the crystal rate over divisors 1/5/6/8, powers of two to 128, and 15/16.
// R17: Divisors, mode, pattern bit and training count are static register settings.
module rdcr_top
    import rdcr_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        SLICER_IN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             RX_DATA,
    output logic             RECOVERED_BIT_CLOCK,
    output logic             TRAIN_END_FLAG,
    output logic             IRQ
);

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        rdcr_mode_e  receive_mode_select;
        logic        two;
        logic [4:0]  training_length_count;
        logic [1:0]  d1_code;
        logic [2:0]  d2_exp;
        logic        d3_sel;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [31:0] rdata;
        rdcr_mode_e  mode_prev;
        logic        dg_prev;
        logic        seen;
        logic [4:0]  ph;
        logic        mid_bit;
        logic        prev1;
        logic        prev2;
        logic [6:0]  tcnt;
        logic        pend;
        logic        rx_out;
        logic        clk_out;
        logic        flag_out;
    } rdcr_top_s;

    rdcr_top_s  st_r;
    rdcr_top_s  st_nxt;

    logic       sample_en;
    logic       os_clk;
    logic       dg_bit;

    logic       active;
    logic       restart;
    logic       dg_edge;
    logic       boundary;
    logic       rise;
    logic       expected;
    logic       new_bit;
    logic       train_evt;
    logic       sync_evt;
    logic [4:0] d3v;
    logic [4:0] half;
    logic [4:0] last;
    logic [6:0] tmin;

    ////////////////////////////////////////////////////////////////////////
    // Rate divider and deglitch filter.

    rdcr_div u_div (
        .clk                 (REF_CLK),
        .rst                 (RST),
        .rate_divisor_first  (st_r.d1_code),
        .rate_divisor_second (st_r.d2_exp),
        .sample_en           (sample_en),
        .os_clk              (os_clk)
    );

    rdcr_dglt #(
        .TAPS (DG_TAPS)
    ) u_dglt (
        .clk       (REF_CLK),
        .rst       (RST),
        .sample_en (sample_en),
        .din       (st_r.sync2),
        .dout      (dg_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Expected next training bit for single or paired alternation.

    function automatic logic train_expect(
        input logic pairs,
        input logic p1,
        input logic p2
    );
        if (!pairs) begin
            train_expect = ~p1;
        end else if (p1 == p2) begin
            train_expect = ~p1;
        end else begin
            train_expect = p1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bit clock level: high over the second half of each recovered bit.

    function automatic logic bit_clock_level(
        input logic       synced,
        input logic [4:0] phase,
        input logic [4:0] centre
    );
        bit_clock_level = synced && (phase >= centre);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer for the register port.

    function automatic logic [31:0] read_word(
        input rdcr_top_s s,
        input logic [7:0] a
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            OFS_CTRL: begin
                w[CTRL_MODE_LSB +: 2] = s.receive_mode_select;
                w[CTRL_TWO_BIT]       = s.two;
                w[CTRL_TCNT_LSB +: 5] = s.training_length_count;
            end
            OFS_DIV: begin
                w[DIV_D1_LSB +: 2] = s.d1_code;
                w[DIV_D2_LSB +: 3] = s.d2_exp;
                w[DIV_D3_BIT]      = s.d3_sel;
            end
            OFS_STAT: begin
                w[1:0] = s.stat;
            end
            OFS_MASK: begin
                w[1:0] = s.mask;
            end
            OFS_STATE: begin
                w[0]    = s.seen;
                w[1]    = s.rx_out;
                w[2]    = s.dg_prev;
                w[9:3]  = s.tcnt;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt       = st_r;
        // The slicer pin is asynchronous, so logic reads only the second stage.
        st_nxt.sync1 = SLICER_IN;
        st_nxt.sync2 = st_r.sync1;

        d3v      = st_r.d3_sel ? D3_HIGH : D3_LOW; // R16
        half     = d3v >> 1;
        last     = d3v - 5'h01;
        tmin     = 7'({st_r.training_length_count, 2'b00}) + 7'(st_r.two) + TRAIN_BASE; // R13
        active   = (st_r.receive_mode_select == RDCR_RECOVER) ||
                   (st_r.receive_mode_select == RDCR_TRAIN);
        restart  = (st_r.receive_mode_select != st_r.mode_prev);
        dg_edge  = sample_en && (dg_bit != st_r.dg_prev);
        boundary = 1'b0;
        rise     = 1'b0;
        new_bit  = st_r.mid_bit;
        expected = train_expect(st_r.two, st_r.prev1, st_r.prev2); // R11
        train_evt = 1'b0;
        sync_evt  = 1'b0;

        st_nxt.mode_prev = st_r.receive_mode_select;
        if (sample_en) begin
            st_nxt.dg_prev = dg_bit;
        end

        // Register port.
        // One strobe per cycle; read data stand one cycle and are zero otherwise.
        st_nxt.rdata = 32'h0000_0000;
        if (WR) begin
            unique case (ADDR)
                OFS_CTRL: begin
                    st_nxt.receive_mode_select   = rdcr_mode_e'(WDATA[CTRL_MODE_LSB +: 2]); // R17
                    st_nxt.two                   = WDATA[CTRL_TWO_BIT];
                    st_nxt.training_length_count = WDATA[CTRL_TCNT_LSB +: 5];
                end
                OFS_DIV: begin
                    st_nxt.d1_code = WDATA[DIV_D1_LSB +: 2]; // R17
                    st_nxt.d2_exp  = WDATA[DIV_D2_LSB +: 3];
                    st_nxt.d3_sel  = WDATA[DIV_D3_BIT];
                end
                OFS_STAT: begin
                    st_nxt.stat = st_r.stat & ~WDATA[1:0];
                end
                OFS_MASK: begin
                    st_nxt.mask = WDATA[1:0];
                end
                default: begin
                end
            endcase
        end
        if (RD) begin
            st_nxt.rdata = read_word(st_r, ADDR);
        end

        // Bit clock recovery: phase counts sample enables across one bit.
        if (!active || restart) begin
            st_nxt.seen = 1'b0; // R14
            st_nxt.ph   = 5'h00;
            st_nxt.tcnt = 7'h00;
            st_nxt.pend = 1'b0;
        end else if (sample_en) begin
            if (dg_edge) begin
                st_nxt.ph = 5'h00; // R6
                st_nxt.seen = 1'b1; // R9
                sync_evt = !st_r.seen;
                boundary = st_r.seen && (st_r.ph >= half);
            end else if (st_r.ph >= last) begin
                st_nxt.ph = 5'h00;
                boundary  = st_r.seen;
            end else begin
                st_nxt.ph = st_r.ph + 5'h01;
                rise      = st_r.seen && (st_r.ph + 5'h01 == half); // R15
            end
        end

        // Data is taken at the bit centre and shown at the next bit start.
        if (rise) begin
            st_nxt.mid_bit = dg_bit; // R15
        end
        if (boundary) begin
            st_nxt.rx_out = new_bit; // R7
            st_nxt.prev1  = new_bit;
            st_nxt.prev2  = st_r.prev1;
        end

        // Training sequence end detection.
        if (boundary && (st_r.receive_mode_select == RDCR_TRAIN)) begin
            if ((st_r.tcnt == 7'h00) || (new_bit == expected)) begin
                if (st_r.tcnt != TRAIN_SAT) begin
                    st_nxt.tcnt = st_r.tcnt + 7'h01; // R11
                end
            end else begin
                // The odd bit may open a new training run, so counting restarts at one.
                st_nxt.pend = (st_r.tcnt >= tmin); // R12
                st_nxt.tcnt = 7'h01; // R14
            end
        end
        if (rise) begin
            st_nxt.flag_out = st_r.pend &&
                              (st_r.receive_mode_select == RDCR_TRAIN); // R12
            train_evt       = st_nxt.flag_out;
            st_nxt.pend     = 1'b0;
        end

        // Output selection per mode.
        unique case (st_r.receive_mode_select) // R1
            RDCR_RAW: begin
                st_nxt.rx_out   = st_r.sync2; // R2
                st_nxt.clk_out  = 1'b0; // R2
                st_nxt.flag_out = 1'b0; // R2
            end
            RDCR_DEGLITCH: begin
                st_nxt.rx_out   = dg_bit; // R5
                st_nxt.clk_out  = os_clk; // R5
                st_nxt.flag_out = 1'b0; // R5
            end
            RDCR_RECOVER: begin
                st_nxt.clk_out  = bit_clock_level(st_nxt.seen, st_nxt.ph, half); // R6
                st_nxt.flag_out = 1'b0; // R6
            end
            RDCR_TRAIN: begin
                st_nxt.clk_out  = bit_clock_level(st_nxt.seen, st_nxt.ph, half); // R9
            end
        endcase
        // A mode change forces the clock low so no edge of the old mode reaches the controller.
        if (restart) begin
            st_nxt.clk_out  = 1'b0;
            st_nxt.flag_out = 1'b0;
        end

        // Events are applied after the clear so a set wins.
        if (train_evt) begin
            st_nxt.stat[STAT_TRAIN_BIT] = 1'b1;
        end
        if (sync_evt) begin
            st_nxt.stat[STAT_SYNC_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_r                       <= '0;
            st_r.receive_mode_select   <= rdcr_mode_e'(MODE_RST);
            st_r.mode_prev             <= rdcr_mode_e'(MODE_RST);
            st_r.two                   <= TWO_RST;
            st_r.training_length_count <= TCNT_RST;
            st_r.d1_code               <= D1_RST;
            st_r.d2_exp                <= D2_RST;
            st_r.d3_sel                <= D3_RST;
            st_r.stat                  <= STAT_RST;
            st_r.mask                  <= MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign RDATA               = st_r.rdata;
    assign RX_DATA             = st_r.rx_out;
    assign RECOVERED_BIT_CLOCK = st_r.clk_out;
    assign TRAIN_END_FLAG      = st_r.flag_out;
    assign IRQ                 = |(st_r.stat & st_r.mask);

endmodule

// *** verif/rdcr_mcu.sv ***
// Controller model: latches received data on each rising bit clock edge.
// Assumes bit clock and data come straight from the block outputs.
`timescale 1ns/1ps
module rdcr_mcu (
    input  wire logic       bit_clk,
    input  wire logic       data,
    output logic      [7:0] cap_bits,
    output int              n_rise,
    output realtime         t_period,
    output realtime         t_high
);
    realtime t_rise;

    initial begin
        cap_bits = 8'h00;
        n_rise   = 0;
        t_period = 0;
        t_high   = 0;
        t_rise   = 0;
    end

    always @(posedge bit_clk) begin
        cap_bits = {cap_bits[6:0], data};
        n_rise   = n_rise + 1;
        t_period = $realtime - t_rise;
        t_rise   = $realtime;
    end

    always @(negedge bit_clk) begin
        t_high = $realtime - t_rise;
    end
endmodule

// *** verif/rdcr_asserts.sv ***
// Checker for the receive recovery block, bound to its top module.
// Assumes one clock and a register master that follows the port rules.
`timescale 1ns/1ps
module rdcr_asserts
    import rdcr_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        SLICER_IN,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        RX_DATA,
    input wire logic        RECOVERED_BIT_CLOCK,
    input wire logic        TRAIN_END_FLAG,
    input wire logic        IRQ
);
    logic [1:0] mode_r;
    logic [3:0] age_r;
    logic       edge_seen_r;
    logic       slicer_d_r;

    // Mode shadow and the number of cycles since the last mode write.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_r      <= RDCR_RAW;
            age_r       <= 4'h0;
            edge_seen_r <= 1'b0;
            slicer_d_r  <= 1'b0;
        end else begin
            if (WR && ADDR == OFS_CTRL) begin
                mode_r <= WDATA[1:0];
            end
            age_r       <= (WR && ADDR == OFS_CTRL) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
            slicer_d_r  <= SLICER_IN;
            edge_seen_r <= edge_seen_r | (SLICER_IN != slicer_d_r);
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_bit_rise;
        $rose(RECOVERED_BIT_CLOCK);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_RAW_DATA: assert property (mode_r == RDCR_RAW && age_r > 4'h3 |-> RX_DATA == $past(SLICER_IN, 3))
        else $error("raw data does not follow the slicer bit");
    AST_RAW_QUIET: assert property (mode_r == RDCR_RAW && age_r > 4'h1 |-> !RECOVERED_BIT_CLOCK && !TRAIN_END_FLAG)
        else $error("clock or flag active in raw mode");
    AST_NO_FLAG: assert property (mode_r != RDCR_TRAIN && age_r > 4'h2 |-> !TRAIN_END_FLAG)
        else $error("flag active outside self train mode");
    AST_DATA_AT_FALL: assert property (mode_r[1] && age_r > 4'h2 && RX_DATA != $past(RX_DATA)
                                       |-> $fell(RECOVERED_BIT_CLOCK))
        else $error("recovered data changed away from a clock fall");
    AST_CLK_WAIT: assert property (mode_r[1] && !edge_seen_r && age_r > 4'h1 |-> !RECOVERED_BIT_CLOCK)
        else $error("bit clock running before any data edge");
    AST_FLAG_RISE: assert property ($rose(TRAIN_END_FLAG) |-> s_bit_rise)
        else $error("flag rose away from a bit clock rise");
    AST_FLAG_FALL: assert property ($fell(TRAIN_END_FLAG) && age_r > 4'h3 |-> s_bit_rise)
        else $error("flag fell away from a bit clock rise");
    AST_RD_QUIET: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside the cycle after a read");
    AST_IRQ_OFF: assert property (WR && ADDR == OFS_MASK && WDATA[1:0] == 2'h0 |=> !IRQ)
        else $error("interrupt high with every event masked");
endmodule

bind rdcr_top rdcr_asserts u_rdcr_asserts (
    .REF_CLK            (REF_CLK),
    .RST                (RST),
    .SLICER_IN          (SLICER_IN),
    .ADDR               (ADDR),
    .WDATA              (WDATA),
    .WR                 (WR),
    .RD                 (RD),
    .RDATA              (RDATA),
    .RX_DATA            (RX_DATA),
    .RECOVERED_BIT_CLOCK(RECOVERED_BIT_CLOCK),
    .TRAIN_END_FLAG     (TRAIN_END_FLAG),
    .IRQ                (IRQ)
);

// *** verif/rdcr_top_test.sv ***
// Self-checking bench for the receive recovery block and its registers.
// Assumes the checker is bound in and the controller model is alongside.
`timescale 1ns/1ps
module rdcr_top_test
    import rdcr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
    } rdcr_row_s;

    localparam int         BIT_CYC = 16;
    localparam logic [11:0] PAT    = 12'hB4D;
    localparam rdcr_row_s  ROWS [16] = '{
        '{OFS_CTRL, 1'b0, 32'h0, 32'h2}, '{OFS_DIV, 1'b0, 32'h0, 32'h0},
        '{OFS_STAT, 1'b0, 32'h0, 32'h0}, '{OFS_MASK, 1'b0, 32'h0, 32'h0},
        '{OFS_STATE, 1'b0, 32'h0, 32'h0}, '{8'h14, 1'b0, 32'h0, 32'h0},
        '{OFS_CTRL, 1'b1, 32'hFC, 32'h0}, '{OFS_CTRL, 1'b0, 32'h0, 32'hFC},
        '{OFS_DIV, 1'b1, 32'h3F, 32'h0}, '{OFS_DIV, 1'b0, 32'h0, 32'h3F},
        '{8'h14, 1'b1, 32'hFFFFFFFF, 32'h0}, '{8'h14, 1'b0, 32'h0, 32'h0},
        '{OFS_STATE, 1'b1, 32'hFFFF, 32'h0}, '{OFS_STATE, 1'b0, 32'h0, 32'h0},
        '{OFS_MASK, 1'b1, 32'h3, 32'h0}, '{OFS_CTRL, 1'b1, 32'h0, 32'h0}};

    logic        clk, rst, slicer, wr, rd, rx_data, bclk, flag, irq;
    logic [7:0]  addr, cap;
    logic [31:0] wdata, rdata;
    int          n_mismatch = 0;
    int          compares   = 0;
    int          n_rise, n0, hi;
    realtime     t_period, t_high;

    rdcr_top u_rdcr_top (.REF_CLK(clk), .RST(rst), .SLICER_IN(slicer), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .RX_DATA(rx_data), .RECOVERED_BIT_CLOCK(bclk), .TRAIN_END_FLAG(flag), .IRQ(irq));
    rdcr_mcu u_rdcr_mcu (.bit_clk(bclk), .data(rx_data), .cap_bits(cap), .n_rise(n_rise), .t_period(t_period),
        .t_high(t_high));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask

    task automatic irq_chk(input logic e);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    // Sends twelve training bits, then zeros, and counts flag cycles.
    task automatic train(input logic two, input logic [4:0] tc, input int n_exp);
        int   n_flag;
        logic seen;
        logic b;
        n_flag = 0;
        seen   = 1'b0;
        reg_wr(OFS_CTRL, 32'h0);
        reg_wr(OFS_CTRL, {24'h0, tc, two, 2'h3});
        for (int i = 0; i < 18; i++) begin
            b = (i < 12) && ((two ? i / 2 : i) % 2 == 0);
            slicer <= b;
            repeat (BIT_CYC) begin
                @(posedge clk);
                if (flag === 1'b1) begin
                    if (!seen) begin
                        chk("captured", two ? 32'h18 : 32'h14, {27'h0, cap[4:0]});
                        chk("bit_period", 32'(BIT_CYC * 25), 32'(int'(t_period)));
                        chk("clock_high", 32'(BIT_CYC * 25 / 2), 32'(int'(t_high)));
                    end
                    seen = 1'b1;
                    n_flag++;
                end
            end
        end
        chk("flag_cycles", 32'(BIT_CYC * n_exp), 32'(n_flag));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst    = 1'b1;
        slicer = 1'b0;
        addr   = 8'h00;
        wdata  = 32'h0;
        wr     = 1'b0;
        rd     = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reg_wr(OFS_CTRL, 32'h2);
        repeat (64) @(posedge clk);
        chk("rises_before_edge", 32'h0, 32'(n_rise));
        for (int i = 0; i < 16; i++) begin
            if (ROWS[i].w) reg_wr(ROWS[i].a, ROWS[i].d);
            else rd_chk(ROWS[i].a, ROWS[i].e);
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            slicer <= PAT[i];
            #1;
            if (i >= 3) chk("raw_data", {31'h0, PAT[i - 3]}, {31'h0, rx_data});
            chk("raw_quiet", 32'h0, {30'h0, bclk, flag});
        end
        reg_wr(OFS_DIV, 32'h1);
        reg_wr(OFS_CTRL, 32'h1);
        slicer <= 1'b1;
        repeat (10) @(posedge clk);
        slicer <= 1'b0;
        hi = 0;
        repeat (60) begin
            @(posedge clk);
            if (rx_data === 1'b1) hi++;
        end
        chk("glitch_high", 32'h0, 32'(hi));
        slicer <= 1'b1;
        n0 = n_rise;
        repeat (50) @(posedge clk);
        chk("os_rises", 32'hA, 32'(n_rise - n0));
        chk("dg_data", 32'h1, {31'h0, rx_data});
        reg_wr(OFS_DIV, 32'h20);
        reg_wr(OFS_STAT, 32'h3);
        train(1'b0, 5'h01, 1);
        irq_chk(1'b1);
        rd_chk(OFS_STAT, 32'h3);
        reg_wr(OFS_STAT, 32'h1);
        rd_chk(OFS_STAT, 32'h2);
        reg_wr(OFS_MASK, 32'h1);
        irq_chk(1'b0);
        reg_wr(OFS_STAT, 32'h2);
        train(1'b1, 5'h01, 1);
        irq_chk(1'b1);
        reg_wr(OFS_MASK, 32'h0);
        irq_chk(1'b0);
        reg_wr(OFS_STAT, 32'h3);
        train(1'b0, 5'h04, 0);
        train(1'b1, 5'h04, 0);
        rd_chk(OFS_STAT, 32'h2);
        close_out;
    end

    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
endmodule
